// [pkg/rcip_pkg.sv]
// Constants and types for the reset sequencer and clock/interrupt pins
package rcip_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_INTC = 8'h08;
    localparam logic [7:0] ADDR_PUC  = 8'h0C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_BUS_CLOCK_OUTPUT = 0;
    localparam int CTRL_WDOG = 1;
    localparam int CTRL_CMON = 2;
    localparam int CTRL_STR  = 4;
    localparam int INTC_EDGE = 0;
    localparam int INTC_EN   = 1;
    localparam int INTC_MASK = 2;
    localparam int INTC_FLAG = 3;
    localparam int PUC_EN    = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       WDOG_EN_RST = 1'b1;
    localparam logic       CMON_EN_RST = 1'b0;
    localparam logic [1:0] STR_RST     = 2'h0;
    localparam logic [2:0] INTC_RST    = 3'h6;
    localparam logic       PUC_RST     = 1'b1;

    // ------------------------------------------------------------
    // Sequence counter width in bits, and timing in clock cycles
    // ------------------------------------------------------------
    localparam int CNT_W      = 12;
    localparam int OSC_CYC    = 4096;
    localparam int DRIVE_CYC  = 16;
    localparam int SAMPLE_CYC = 9;

    // ------------------------------------------------------------
    // Start vectors
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_NORMAL = 16'hFFFE;
    localparam logic [15:0] VEC_CMON   = 16'hFFFC;
    localparam logic [15:0] VEC_WDOG   = 16'hFFFA;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_OSC   = 2'h0,
        SEQ_DRIVE = 2'h1,
        SEQ_RISE  = 2'h3,
        SEQ_RUN   = 2'h2
    } seq_state_t;

    typedef enum logic [1:0] {
        MODE_NSC  = 2'h0,
        MODE_SSC  = 2'h1,
        MODE_SPER = 2'h2,
        MODE_EXP  = 2'h3
    } mode_t;

endpackage

// [logic/reset_clock_irq_pins.sv]
// Reset sequencer, bus clock gating and maskable interrupt pin logic
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module reset_clock_irq_pins (
    // Clock and power-on reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Reset pin, open drain
    input  wire logic              rst_pin_in,
    output logic                   rst_pin_out,
    output logic                   rst_pin_oe,
    // Failure sources and mode pins
    input  wire logic              wdog_timeout,
    input  wire logic              clkmon_fail,
    input  wire logic [1:0]        mode_pins,
    // Core side
    output logic                   core_reset_n,
    output logic      [15:0]       reset_vector,
    input  wire logic              stop_req,
    input  wire logic              slow_access,
    // Bus clock pin
    output logic                   bus_clock_output,
    output logic                   bus_clock_oe,
    // Maskable interrupt pin
    input  wire logic              irq_pin_n,
    output logic                   irq_pullup_en,
    output logic                   irq_request
);
    import rcip_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    seq_state_t         state_reg;
    mode_t              mode_reg;
    logic [CNT_W-1:0]   cnt_reg;
    logic [3:0]         sync1_reg;
    logic [3:0]         sync2_reg;
    logic               rst_s;
    logic               irq_s;
    logic               irq_prev_reg;
    logic               bus_clock_output_en_reg;
    logic               wdog_en_reg;
    logic               cmon_en_reg;
    logic [1:0]         str_cfg_reg;
    logic [1:0]         str_cnt_reg;
    logic               edge_sel_reg;
    logic               pin_en_reg;
    logic               imask_reg;
    logic               flag_reg;
    logic               pullup_reg;
    logic               wdog_lat_reg;
    logic               cmon_lat_reg;
    logic               wr_pend_reg;
    logic [7:0]         wr_addr_reg;
    logic [31:0]        rd_next;
    logic               running;
    logic               wdog_ev;
    logic               cmon_ev;
    logic               ext_ev;
    logic               decide;
    logic               bus_clock_output_run;
    logic               str_hold;
    logic               wr_ctrl;
    logic               wr_intc;
    logic               wr_puc;
    logic               arst_n;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Reset pin, interrupt pin and mode straps, two stages each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
        end else begin
            sync1_reg <= {mode_pins, irq_pin_n, rst_pin_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign rst_s = sync2_reg[0];
    assign irq_s = sync2_reg[1];

    // ------------------------------------------------------------
    // Reset events
    // ------------------------------------------------------------
    assign running = (state_reg == SEQ_RUN);
    assign wdog_ev = wdog_timeout & wdog_en_reg;
    assign cmon_ev = clkmon_fail & cmon_en_reg;
    assign ext_ev  = running & ~rst_s;
    assign decide  = (state_reg == SEQ_RISE) &&
                     (cnt_reg == CNT_W'(SAMPLE_CYC - 1));

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    // Power-on starts in the oscillator delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= SEQ_OSC;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                SEQ_OSC: begin
                    if (cnt_reg == CNT_W'(OSC_CYC - 1)) begin
                        state_reg <= SEQ_DRIVE;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                SEQ_DRIVE: begin
                    if (cnt_reg == CNT_W'(DRIVE_CYC - 1)) begin
                        state_reg <= SEQ_RISE;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                SEQ_RISE: begin
                    // A pin still held low keeps us here, so a late
                    // release cannot look like a fresh external reset
                    if (decide && rst_s) begin
                        state_reg <= SEQ_RUN;
                        cnt_reg   <= '0;
                    end else if (!decide) begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    // Clock failure needs the oscillator delay again
                    if (cmon_ev) begin
                        state_reg <= SEQ_OSC;
                    end else if (wdog_ev || ext_ev) begin
                        state_reg <= SEQ_DRIVE;
                    end
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    // Pin pulled low only in the delay and drive phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_pin_oe  <= 1'b1;
            rst_pin_out <= 1'b0;
        end else begin
            rst_pin_oe  <= (state_reg == SEQ_OSC) ||
                           (state_reg == SEQ_DRIVE);
            rst_pin_out <= 1'b0;
        end
    end

    // Raw pin low asserts the core reset without a clock
    assign arst_n = hresetn & rst_pin_in;

    // Release only on a clock edge after the sequence ends
    always_ff @(posedge hclk or negedge arst_n) begin
        if (!arst_n) begin
            core_reset_n <= 1'b0;
        end else begin
            core_reset_n <= running;
        end
    end

    // ------------------------------------------------------------
    // Failure latches and vector choice
    // ------------------------------------------------------------
    // A new failure in the decision cycle survives the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdog_lat_reg <= 1'b0;
            cmon_lat_reg <= 1'b0;
        end else begin
            wdog_lat_reg <= (wdog_lat_reg & ~decide) | wdog_ev;
            cmon_lat_reg <= (cmon_lat_reg & ~decide) | cmon_ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_vector <= VEC_NORMAL;
        end else if (decide) begin
            if (!rst_s) begin
                reset_vector <= VEC_NORMAL;
            end else if (cmon_lat_reg) begin
                reset_vector <= VEC_CMON;
            end else if (wdog_lat_reg) begin
                reset_vector <= VEC_WDOG;
            end else begin
                reset_vector <= VEC_NORMAL;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode capture and control register
    // ------------------------------------------------------------
    // Straps followed throughout reset, frozen while running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= MODE_NSC;
        end else if (!running) begin
            mode_reg <= mode_t'(sync2_reg[3:2]);
        end
    end

    // Defaults reloaded in every reset sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_clock_output_en_reg <= 1'b0;
            wdog_en_reg <= WDOG_EN_RST;
            cmon_en_reg <= CMON_EN_RST;
            str_cfg_reg <= STR_RST;
        end else if (!running) begin
            bus_clock_output_en_reg <= (sync2_reg[3:2] == MODE_SSC) ||
                           (sync2_reg[3:2] == MODE_EXP);
            wdog_en_reg <= WDOG_EN_RST;
            cmon_en_reg <= CMON_EN_RST;
            str_cfg_reg <= STR_RST;
        end else if (wr_ctrl) begin
            bus_clock_output_en_reg <= hwdata[CTRL_BUS_CLOCK_OUTPUT];
            wdog_en_reg <= hwdata[CTRL_WDOG];
            cmon_en_reg <= hwdata[CTRL_CMON];
            str_cfg_reg <= hwdata[CTRL_STR +: 2];
        end
    end

    // ------------------------------------------------------------
    // Bus clock output
    // ------------------------------------------------------------
    assign bus_clock_output_run = running & bus_clock_output_en_reg & ~stop_req &
                      (mode_reg != MODE_SPER);
    assign str_hold = bus_clock_output & slow_access &
                      (str_cnt_reg != str_cfg_reg);

    // High phase held for the programmed extra cycles during a slow access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_clock_output <= 1'b0;
            str_cnt_reg      <= 2'h0;
        end else if (!bus_clock_output_run) begin
            bus_clock_output <= 1'b0;
            str_cnt_reg      <= 2'h0;
        end else if (str_hold) begin
            str_cnt_reg <= str_cnt_reg + 1'b1;
        end else begin
            bus_clock_output <= ~bus_clock_output;
            str_cnt_reg      <= 2'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_clock_oe <= 1'b0;
        end else begin
            bus_clock_oe <= (mode_reg != MODE_SPER);
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    // Control bits and pull-up back to defaults during reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {imask_reg, pin_en_reg, edge_sel_reg} <= INTC_RST;
            pullup_reg <= PUC_RST;
        end else if (!running) begin
            {imask_reg, pin_en_reg, edge_sel_reg} <= INTC_RST;
            pullup_reg <= PUC_RST;
        end else begin
            if (wr_intc) begin
                edge_sel_reg <= hwdata[INTC_EDGE];
                pin_en_reg   <= hwdata[INTC_EN];
                imask_reg    <= hwdata[INTC_MASK];
            end
            if (wr_puc) begin
                pullup_reg <= hwdata[PUC_EN];
            end
        end
    end

    // Falling edge flag; an edge beats a write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_prev_reg <= 1'b1;
            flag_reg     <= 1'b0;
        end else begin
            irq_prev_reg <= irq_s;
            if (irq_prev_reg && !irq_s && edge_sel_reg && pin_en_reg) begin
                flag_reg <= 1'b1;
            end else if (!running ||
                         (wr_intc && hwdata[INTC_FLAG])) begin
                flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_request   <= 1'b0;
            irq_pullup_en <= 1'b1;
        end else begin
            irq_request   <= running & pin_en_reg & ~imask_reg &
                             (edge_sel_reg ? flag_reg : ~irq_s);
            irq_pullup_en <= pullup_reg;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    // Address phase captured; write data lands next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= hsel & htrans[1] & hready & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    assign wr_ctrl = wr_pend_reg && (wr_addr_reg == ADDR_CTRL);
    assign wr_intc = wr_pend_reg && (wr_addr_reg == ADDR_INTC);
    assign wr_puc  = wr_pend_reg && (wr_addr_reg == ADDR_PUC);

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        if (haddr[7:0] == ADDR_CTRL) begin
            rd_next[CTRL_BUS_CLOCK_OUTPUT]     = bus_clock_output_en_reg;
            rd_next[CTRL_WDOG]     = wdog_en_reg;
            rd_next[CTRL_CMON]     = cmon_en_reg;
            rd_next[CTRL_STR +: 2] = str_cfg_reg;
        end else if (haddr[7:0] == ADDR_STAT) begin
            rd_next[1:0]   = mode_reg;
            rd_next[2]     = wdog_lat_reg;
            rd_next[3]     = cmon_lat_reg;
            rd_next[4]     = irq_s;
            rd_next[5]     = running;
            rd_next[31:16] = reset_vector;
        end else if (haddr[7:0] == ADDR_INTC) begin
            rd_next[INTC_EDGE] = edge_sel_reg;
            rd_next[INTC_EN]   = pin_en_reg;
            rd_next[INTC_MASK] = imask_reg;
            rd_next[INTC_FLAG] = flag_reg;
        end else if (haddr[7:0] == ADDR_PUC) begin
            rd_next[PUC_EN] = pullup_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= rd_next;
            end
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_bus_clock_output_half;
        bus_clock_output_run && !str_hold |=> bus_clock_output != $past(bus_clock_output);
    endproperty
    a_bus_clock_output_half: assert property (p_bus_clock_output_half)
        else $error("bus clock failed to toggle");

    property p_bus_clock_output_stop;
        stop_req |=> !bus_clock_output ##1 !bus_clock_output || !stop_req;
    endproperty
    a_bus_clock_output_stop: assert property (p_bus_clock_output_stop)
        else $error("bus clock ran in STOP");

    property p_periph_input;
        mode_reg == MODE_SPER |=> !bus_clock_oe && !bus_clock_output;
    endproperty
    a_periph_input: assert property (p_periph_input)
        else $error("bus clock driven in peripheral mode");

    property p_drive_len;
        $fell(state_reg == SEQ_DRIVE) && state_reg == SEQ_RISE
            |-> $past(cnt_reg) == CNT_W'(DRIVE_CYC - 1) ##1 !rst_pin_oe;
    endproperty
    a_drive_len: assert property (p_drive_len)
        else $error("recovery drive length wrong");

    property p_osc_hold;
        state_reg == SEQ_OSC && cnt_reg > 0 |-> rst_pin_oe;
    endproperty
    a_osc_hold: assert property (p_osc_hold)
        else $error("pin released during oscillator delay");

    property p_ext_vec;
        decide && !rst_s && !wdog_ev && !cmon_ev |=>
            reset_vector == VEC_NORMAL && !wdog_lat_reg && !cmon_lat_reg;
    endproperty
    a_ext_vec: assert property (p_ext_vec)
        else $error("external reset not recognised");

    property p_cmon_vec;
        decide && rst_s && cmon_lat_reg |=> reset_vector == VEC_CMON;
    endproperty
    a_cmon_vec: assert property (p_cmon_vec)
        else $error("clock monitor vector not taken");

    property p_wdog_vec;
        decide && rst_s && !cmon_lat_reg && wdog_lat_reg
            |=> reset_vector == VEC_WDOG;
    endproperty
    a_wdog_vec: assert property (p_wdog_vec)
        else $error("watchdog vector not taken");

    property p_core_held;
        !running |=> !core_reset_n;
    endproperty
    a_core_held: assert property (p_core_held)
        else $error("core released during sequence");

    property p_irq_defaults;
        !running |=> imask_reg && pin_en_reg && !edge_sel_reg ##1 irq_pullup_en;
    endproperty
    a_irq_defaults: assert property (p_irq_defaults)
        else $error("interrupt defaults not restored");

    property p_latch;
        wdog_ev |=> wdog_lat_reg;
    endproperty
    a_latch: assert property (p_latch)
        else $error("watchdog timeout not latched");

    c_ext: cover property (decide && !rst_s);
    c_cmon: cover property (decide && rst_s && cmon_lat_reg);
    c_wdog: cover property (decide && rst_s && wdog_lat_reg);
    c_irq: cover property ($rose(irq_request));

endmodule

// [verification/ext_reset_circuit.sv]
// Far-side model: external reset circuit and interrupt source
`timescale 1ns/1ps
module ext_reset_circuit (
    // Clock and device drive
    input  wire logic hclk,
    input  wire logic rst_pin_oe,
    input  wire logic rst_pin_out,
    input  wire logic irq_pullup_en,
    // Far-side requests
    input  wire logic ext_low,
    input  wire logic irq_low,
    // Wire levels
    output logic      rst_pin_in,
    output logic      irq_pin_n
);
    logic flip = 1'b0;
    // Reset wire has a pull-up; either side may pull it low
    assign rst_pin_in = !(ext_low || (rst_pin_oe && !rst_pin_out));
    // Floating pin wanders so a lost pull-up cannot pass as high
    always @(posedge hclk) begin
        flip <= !flip;
    end
    assign irq_pin_n = irq_low ? 1'b0 : (irq_pullup_en ? 1'b1 : flip);
endmodule

// [verification/reset_clock_irq_pins_tb.sv]
// Self-checking bench for the reset sequencer and pin logic
`timescale 1ns/1ps
module reset_clock_irq_pins_tb;
    import rcip_pkg::*;
    // ----
    // Signals
    // ----
    typedef struct packed {
        mode_t       m;
        int          ev;
        logic [15:0] v;
        int          len;
        logic        oe;
    } row_t;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0, mode_pins = 0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, rst_pin_in, rst_pin_out, rst_pin_oe, ext_low = 0;
    logic        wdog_timeout = 0, clkmon_fail = 0, stop_req = 0, irq_low = 0;
    logic        core_reset_n, slow_access = 0, bus_clock_output, bus_clock_oe;
    logic        irq_pin_n, irq_pullup_en, irq_request;
    logic [15:0] reset_vector;
    int          failures = 0, checks_done = 0, n;
    row_t        rows[3] = '{'{MODE_SPER, 2, VEC_NORMAL, DRIVE_CYC, 1'b0},
                             '{MODE_NSC, 0, VEC_WDOG, DRIVE_CYC, 1'b1},
                             '{MODE_SSC, 1, VEC_CMON, OSC_CYC + DRIVE_CYC, 1'b1}};
    assign hready = hreadyout;
    // ----
    // Design and far side
    // ----
    reset_clock_irq_pins i_reset_clock_irq_pins (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
        .wdog_timeout, .clkmon_fail, .mode_pins, .core_reset_n,
        .reset_vector, .stop_req, .slow_access, .bus_clock_output,
        .bus_clock_oe, .irq_pin_n, .irq_pullup_en, .irq_request);
    ext_reset_circuit i_ext_reset_circuit (.hclk, .rst_pin_oe, .rst_pin_out,
        .irq_pullup_en, .ext_low, .irq_low, .rst_pin_in, .irq_pin_n);
    // 40 MHz clock
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    // ----
    // Tasks
    // ----
    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait on pin drive (0), core reset (1) or hready (2)
    task automatic wait_lvl(int s, logic v);
        for (int i = 0; i < 9000; i++) begin
            @(posedge hclk);
            if ((s == 0 ? rst_pin_oe : s == 1 ? core_reset_n : hready) === v)
                return;
        end
        failures++;
        end_sim;
    endtask
    // Single word transfer; read data lands in rd
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_lvl(2, 1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_lvl(2, 1);
        rd = hrdata;
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        chk("core reset", 0, core_reset_n);
        chk("pin drive", 1, rst_pin_oe);
        wait_lvl(1, 1);
        chk("vector", VEC_NORMAL, reset_vector);
        chk("pull-up", 1, irq_pullup_en);
        xfer(0, ADDR_INTC, 0);
        chk("intc", INTC_RST, rd[2:0]);
        $display("power-on test done");
        // One reset source per row, but row 0 raises the watchdog with the pin; monitor enable reloads after each
        foreach (rows[i]) begin
            mode_pins <= rows[i].m;
            xfer(1, ADDR_CTRL, 32'h6);
            wdog_timeout <= (rows[i].ev != 1);
            clkmon_fail <= (rows[i].ev == 1);
            ext_low <= (rows[i].ev == 2);
            @(posedge hclk);
            wdog_timeout <= 0;
            clkmon_fail <= 0;
            wait_lvl(0, 1);
            for (n = 0; rst_pin_oe === 1'b1 && n < 9000; n++) @(posedge hclk);
            chk("drive span", rows[i].len, n);
            repeat (7) @(posedge hclk);
            ext_low <= 0;
            wait_lvl(1, 1);
            repeat (2) @(posedge hclk);
            chk("vector", rows[i].v, reset_vector);
            chk("bus clock oe", rows[i].oe, bus_clock_oe);
            xfer(0, ADDR_CTRL, 0);
            chk("bus_clock_output default", rows[i].m == MODE_SSC, rd[0]);
            $display("row %0d done", i);
        end
        // Bus clock runs at half rate, held low in STOP
        rd[0] = bus_clock_output;
        @(posedge hclk);
        chk("half rate", !rd[0], bus_clock_output);
        // Two stretch cycles: high phase lasts three clocks
        xfer(1, ADDR_CTRL, 32'h21);
        slow_access <= 1;
        for (n = 0; bus_clock_output !== 1'b0 && n < 9; n++) @(posedge hclk);
        for (n = 0; bus_clock_output !== 1'b1 && n < 9; n++) @(posedge hclk);
        for (n = 0; bus_clock_output === 1'b1 && n < 9; n++) @(posedge hclk);
        chk("stretch", 1 + 2, n);
        slow_access <= 0;
        // Pin falls while still in level mode and masked
        irq_low <= 1;
        stop_req <= 1;
        repeat (3) @(posedge hclk);
        rd[0] = bus_clock_output;
        @(posedge hclk);
        chk("stop", rd[0], bus_clock_output);
        stop_req <= 0;
        $display("bus clock test done");
        // Pin held low: edge mode ignores it, level mode requests
        xfer(1, ADDR_INTC, 32'h3);
        repeat (3) @(posedge hclk);
        chk("edge mode", 0, irq_request);
        // A real falling edge must raise the request
        irq_low <= 0;
        repeat (3) @(posedge hclk);
        irq_low <= 1;
        repeat (6) @(posedge hclk);
        chk("edge seen", 1, irq_request);
        xfer(1, ADDR_INTC, 32'h2);
        repeat (4) @(posedge hclk);
        chk("level mode", 1, irq_request);
        xfer(1, ADDR_INTC, 32'h0);
        repeat (3) @(posedge hclk);
        chk("disabled", 0, irq_request);
        xfer(1, ADDR_PUC, 32'h0);
        xfer(0, ADDR_STAT, 0);
        chk("pull-up off", 0, irq_pullup_en);
        chk("pin level", 0, rd[4]);
        xfer(0, 8'h10, 0);
        chk("unmapped", 0, rd);
        $display("interrupt test done");
        end_sim;
    end
endmodule
